/* rtl/acrc_formatter.sv */
// Purpose: Clamps a raw sample into a 10-bit code and packs a held code
//          into the two result bytes.
// Assumes: The raw sample is the ideal value in code steps, signed.
// Notes:   Purely combinational; the caller registers what it needs.
`timescale 1ns/1ns
`default_nettype none
`include "acrc_params.svh"
module acrc_formatter
  import acrc_pkg::*;
(
  input wire logic signed [15:0] raw_sample,
  input wire logic is_diff,
  input wire acrc_code_t held_code,
  input wire logic left_adjust_select,
  output acrc_code_t clamped_code,
  output logic [7:0] result_low_byte,
  output logic [7:0] result_high_byte
);

  localparam logic signed [15:0] DIFF_POS = 16'sh01FF;
  localparam logic signed [15:0] DIFF_NEG = -16'sh0200;
  localparam logic signed [15:0] SE_TOP = 16'sh03FF;

  // Saturate instead of wrapping, so an overload never flips polarity.
  always_comb
  begin
    if (is_diff)
    begin
      if (raw_sample > DIFF_POS)
        clamped_code = `ACRC_DIFF_MAX;
      else if (raw_sample < DIFF_NEG)
        clamped_code = `ACRC_DIFF_MIN;
      else
        clamped_code = raw_sample[9:0];
    end
    else if (raw_sample < 16'sh0000)
      clamped_code = `ACRC_SE_MIN;
    else if (raw_sample > SE_TOP)
      clamped_code = `ACRC_SE_MAX;
    else
      clamped_code = raw_sample[9:0];
  end

  // Packing follows the live select bit, so a change shows at once.
  always_comb
  begin
    if (left_adjust_select)
    begin
      result_high_byte = held_code[9:2];
      result_low_byte = {held_code[1:0], 6'h00};
    end
    else
    begin
      result_high_byte = {6'h00, held_code[9:8]};
      result_low_byte = held_code[7:0];
    end
  end

endmodule
`default_nettype wire

/* rtl/acrc_params.svh */
// Purpose: Offsets, field positions, reset values and counts for the
//          converter channel and result control block.
// Assumes: Included by its bare name from the two modules; the package does not include it.
// Notes:   Offsets, fields and codes live here; the formatter keeps its own clamp limits as literals.
//
// Functional notes
// - Free running: a conversion keeps the channel latched at its start.
// - Single-ended input above reference yields the full-scale code.
// - Noise-reduction or idle sleep starts a conversion once halted.
// - Completion wakes the sleeping core; request raised even if awake.
// - After a wake the core stays active until a new sleep.
// - Other sleep modes leave the converter enable untouched.
// - With the done flag high both result bytes hold the result.
// - Single-ended result is an unsigned 10-bit code, 0x000 to 0x3FF.
// - Differential result is 10-bit two's complement, -512 to +511.
// - Top result bit is the sign, one meaning negative.
// - Left-adjust one packs the result high; zero packs it low.
// - One channel may feed both differential inputs for offset checks.
// - Start bit reads one while converting; writing zero does nothing.
// - Changing left adjust reformats the held result at once.
`ifndef ACRC_PARAMS_SVH
`define ACRC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ACRC_OFS_SELECT 8'h00
`define ACRC_OFS_CTRL 8'h04
`define ACRC_OFS_RES_LO 8'h08
`define ACRC_OFS_RES_HI 8'h0C
`define ACRC_SELECT_RESET 8'h00
`define ACRC_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACRC_BIT_EN 7
`define ACRC_BIT_START 6
`define ACRC_BIT_FREE 5
`define ACRC_BIT_DONE 4
`define ACRC_BIT_IE 3
`define ACRC_BIT_LAR 5

// ----------------------------------------------------------------------
// Conversion timing in converter clock cycles
// ----------------------------------------------------------------------
`define ACRC_CYC_NORMAL 5'd13
`define ACRC_CYC_FIRST 5'd25
`define ACRC_SH_NORMAL 5'd2
`define ACRC_SH_FIRST 5'd14

// ----------------------------------------------------------------------
// Codes and channel ranges
// ----------------------------------------------------------------------
`define ACRC_SE_MAX 10'h3FF
`define ACRC_SE_MIN 10'h000
`define ACRC_DIFF_MAX 10'h1FF
`define ACRC_DIFF_MIN 10'h200
`define ACRC_CH_DIFF_LO 5'h08
`define ACRC_CH_DIFF_HI 5'h1D
`define ACRC_SLP_IDLE 3'h0
`define ACRC_SLP_NOISE 3'h1

`endif

/* rtl/acrc_pkg.sv */
// Purpose: Types shared by the converter control modules.
// Assumes: Nothing; it does not include the constants header.
// Notes:   States are one-hot so a stray code is easy to spot.
package acrc_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ACRC_IDLE = 3'b001,
    ACRC_WAIT = 3'b010,
    ACRC_CONV = 3'b100
  } acrc_state_t;

  typedef logic [9:0] acrc_code_t;

endpackage

/* rtl/acrc_top.sv */
// Purpose: Control of a 10-bit successive-approximation converter:
//          channel locking, start sequencing, noise-reduction sleep and
//          result presentation over APB.
// Assumes: Single clock pclk; analog front end returns the ideal value of
//          the latched channel when sample_strobe is high.
// Notes:   Outputs are registered; APB answers with no wait states.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "acrc_params.svh"
module acrc_top
  import acrc_pkg::*;
#(
  parameter int PRESCALE_W = 7
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] sample_value,
  output logic sample_strobe,
  output logic [4:0] active_channel,
  output logic [1:0] active_reference,
  output logic conv_busy,
  input wire logic cpu_sleep,
  input wire logic [2:0] sleep_mode,
  output logic conv_irq,
  output logic cpu_wake
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0] input_select_register;
  logic converter_enable_bit;
  logic free_run_select;
  logic conversion_done_flag;
  logic irq_enable;
  logic [2:0] prescale_select;
  acrc_state_t state;
  logic [4:0] conv_cnt;
  logic [4:0] conv_len;
  logic [4:0] sh_point;
  logic first_pending;
  logic act_diff;
  logic signed [15:0] sample_q;
  acrc_code_t result_code;
  logic [PRESCALE_W-1:0] pre_cnt;
  logic adc_tick;
  logic sleep_q;
  logic nr_active;
  acrc_code_t clamped_code;
  logic [7:0] result_low_byte;
  logic [7:0] result_high_byte;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic access;
  logic wr_select;
  logic wr_ctrl;
  logic mapped;
  logic conv_end;
  logic sw_start;
  logic noise_start;
  logic sleep_rise;
  logic sel_is_diff;
  logic [7:0] ctrl_read;
  logic [7:0] div_full;
  logic [PRESCALE_W-1:0] pre_mask;

  // The access phase completes in the single cycle that pready is high.
  assign access = psel && penable && pready;
  assign wr_select = access && pwrite && (paddr == `ACRC_OFS_SELECT);
  assign wr_ctrl = access && pwrite && (paddr == `ACRC_OFS_CTRL);
  assign mapped = (paddr == `ACRC_OFS_SELECT) ||
                  (paddr == `ACRC_OFS_CTRL) ||
                  (paddr == `ACRC_OFS_RES_LO) ||
                  (paddr == `ACRC_OFS_RES_HI);

  // Start bit reads busy whether the start is pending or running.
  assign ctrl_read = {converter_enable_bit, (state != ACRC_IDLE),
                      free_run_select, conversion_done_flag, irq_enable,
                      prescale_select};

  // Setup phase loads read data and ready, so both come from flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable)
      begin
        unique case (paddr)
          `ACRC_OFS_SELECT: prdata <= {24'h000000, input_select_register};
          `ACRC_OFS_CTRL: prdata <= {24'h000000, ctrl_read};
          `ACRC_OFS_RES_LO: prdata <= {24'h000000, result_low_byte};
          `ACRC_OFS_RES_HI: prdata <= {24'h000000, result_high_byte};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // The selection register is free to write at any time; the converter
  // latches channel and reference when a conversion starts, but the
  // left-adjust bit is read live by the formatter.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      input_select_register <= `ACRC_SELECT_RESET;
    else if (wr_select)
      input_select_register <= pwdata[7:0];
  end

  // Sleep never touches the enable: only software clears it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_enable_bit <= 1'b0;
      free_run_select <= 1'b0;
      irq_enable <= 1'b0;
      prescale_select <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      converter_enable_bit <= pwdata[`ACRC_BIT_EN];
      free_run_select <= pwdata[`ACRC_BIT_FREE];
      irq_enable <= pwdata[`ACRC_BIT_IE];
      prescale_select <= pwdata[2:0];
    end
  end

  // Done flag: completion sets it, writing one clears it; set wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conversion_done_flag <= 1'b0;
    else if (conv_end)
      conversion_done_flag <= 1'b1;
    else if (wr_ctrl && pwdata[`ACRC_BIT_DONE])
      conversion_done_flag <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Converter clock prescaler
  // ----------------------------------------------------------------------
  // Divide by two to the select; select zero also divides by two.
  assign div_full = 8'h01 << prescale_select;
  assign pre_mask = PRESCALE_W'(div_full - 8'h01) |
                    PRESCALE_W'(prescale_select == 3'h0);

  // Held in reset while disabled so the first tick is a full period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt <= '0;
      adc_tick <= 1'b0;
    end
    else if (!converter_enable_bit)
    begin
      pre_cnt <= '0;
      adc_tick <= 1'b0;
    end
    else
    begin
      pre_cnt <= ((pre_cnt & pre_mask) == pre_mask) ? '0 :
                 pre_cnt + 1'b1;
      adc_tick <= (pre_cnt & pre_mask) == pre_mask;
    end
  end

  // ----------------------------------------------------------------------
  // Start sources
  // ----------------------------------------------------------------------
  // Writing zero to the start bit is simply not a start.
  assign sw_start = wr_ctrl && pwdata[`ACRC_BIT_START] &&
                    pwdata[`ACRC_BIT_EN] && (state == ACRC_IDLE);
  assign sleep_rise = cpu_sleep && !sleep_q;
  assign noise_start = sleep_rise && converter_enable_bit &&
                       (state == ACRC_IDLE) && !free_run_select &&
                       irq_enable &&
                       ((sleep_mode == `ACRC_SLP_IDLE) ||
                        (sleep_mode == `ACRC_SLP_NOISE));
  assign conv_end = (state == ACRC_CONV) && adc_tick &&
                    (conv_cnt == conv_len);
  // Same-channel pairs are ordinary differential codes and pass through.
  assign sel_is_diff = (input_select_register[4:0] >= `ACRC_CH_DIFF_LO) &&
                       (input_select_register[4:0] <= `ACRC_CH_DIFF_HI);

  // First conversion after enabling runs long to settle the analog side.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_pending <= 1'b1;
    else if (!converter_enable_bit)
      first_pending <= 1'b1;
    else if (state == ACRC_WAIT && adc_tick)
      first_pending <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  // Selection is latched at each start, so a change made while a free
  // running conversion is under way waits for the next one. A write that
  // enables and starts together must start, not be taken for an abort.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ACRC_IDLE;
      conv_cnt <= 5'd0;
      conv_len <= `ACRC_CYC_NORMAL;
      sh_point <= `ACRC_SH_NORMAL;
      active_channel <= 5'h00;
      active_reference <= 2'h0;
      act_diff <= 1'b0;
    end
    else if (!converter_enable_bit && !sw_start)
      state <= ACRC_IDLE;
    else
    begin
      unique case (state)
        ACRC_IDLE:
        begin
          if (sw_start || noise_start)
            state <= ACRC_WAIT;
        end
        ACRC_WAIT:
        begin
          if (adc_tick)
          begin
            state <= ACRC_CONV;
            conv_cnt <= 5'd1;
            conv_len <= first_pending ? `ACRC_CYC_FIRST : `ACRC_CYC_NORMAL;
            sh_point <= first_pending ? `ACRC_SH_FIRST : `ACRC_SH_NORMAL;
            active_channel <= input_select_register[4:0];
            active_reference <= input_select_register[7:6];
            act_diff <= sel_is_diff;
          end
        end
        ACRC_CONV:
        begin
          if (conv_end && free_run_select)
          begin
            conv_cnt <= 5'd1;
            conv_len <= `ACRC_CYC_NORMAL;
            sh_point <= `ACRC_SH_NORMAL;
            active_channel <= input_select_register[4:0];
            active_reference <= input_select_register[7:6];
            act_diff <= sel_is_diff;
          end
          else if (conv_end)
            state <= ACRC_IDLE;
          else if (adc_tick)
            conv_cnt <= conv_cnt + 5'd1;
        end
        default: state <= ACRC_IDLE;
      endcase
    end
  end

  // Strobe asks the front end for a value; it is taken a cycle later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_strobe <= 1'b0;
      sample_q <= 16'sh0000;
    end
    else
    begin
      sample_strobe <= (state == ACRC_CONV) && adc_tick &&
                       (conv_cnt == sh_point);
      if (sample_strobe)
        sample_q <= sample_value;
    end
  end

  // Result only changes at completion, so it stays put until the next completion.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_code <= 10'h000;
    else if (conv_end)
      result_code <= clamped_code;
  end

  // Busy lets port logic hold digital pins still during a conversion.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_busy <= 1'b0;
    else
      conv_busy <= converter_enable_bit && (state == ACRC_CONV);
  end

  // ----------------------------------------------------------------------
  // Sleep and wake
  // ----------------------------------------------------------------------
  // Wake fires once; only a fresh sleep edge can arm it again.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_q <= 1'b0;
      nr_active <= 1'b0;
      cpu_wake <= 1'b0;
    end
    else
    begin
      sleep_q <= cpu_sleep;
      cpu_wake <= conv_end && nr_active && cpu_sleep;
      if (noise_start)
        nr_active <= 1'b1;
      else if (conv_end || !cpu_sleep || !converter_enable_bit)
        nr_active <= 1'b0;
    end
  end

  // The request follows the flag even when another source woke the core.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_irq <= 1'b0;
    else
      conv_irq <= conversion_done_flag && irq_enable;
  end

  // ----------------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------------
  acrc_formatter u_fmt (
    .raw_sample(sample_q),
    .is_diff(act_diff),
    .held_code(result_code),
    .left_adjust_select(input_select_register[`ACRC_BIT_LAR]),
    .clamped_code(clamped_code),
    .result_low_byte(result_low_byte),
    .result_high_byte(result_high_byte)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_start_busy;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == `ACRC_OFS_CTRL)
      |=> prdata[`ACRC_BIT_START] == ($past(state) != ACRC_IDLE);
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start bit does not reflect busy");

  property p_lock;
    @(posedge pclk) disable iff (!presetn)
    (state == ACRC_CONV && !conv_end && converter_enable_bit)
      |=> $stable(active_channel) && $stable(active_reference);
  endproperty
  a_lock: assert property (p_lock)
    else $error("selection moved during conversion");

  property p_done;
    @(posedge pclk) disable iff (!presetn)
    conv_end |=> conversion_done_flag && result_code == $past(clamped_code);
  endproperty
  a_done: assert property (p_done)
    else $error("completion did not flag and store result");

  property p_se_full;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && !act_diff && sample_q > 16'sh03FF)
      |=> result_code == `ACRC_SE_MAX;
  endproperty
  a_se_full: assert property (p_se_full)
    else $error("overrange single-ended not full scale");

  property p_diff_sat;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && act_diff && sample_q < -16'sh0200)
      |=> result_code == `ACRC_DIFF_MIN && result_code[9];
  endproperty
  a_diff_sat: assert property (p_diff_sat)
    else $error("differential underrange did not saturate");

  property p_left;
    @(posedge pclk) disable iff (!presetn)
    input_select_register[`ACRC_BIT_LAR]
      |-> result_high_byte == result_code[9:2] &&
          result_low_byte == {result_code[1:0], 6'h00};
  endproperty
  a_left: assert property (p_left)
    else $error("left adjusted packing wrong");

  property p_sign;
    @(posedge pclk) disable iff (!presetn)
    !input_select_register[`ACRC_BIT_LAR]
      |-> result_high_byte[1] == result_code[9] &&
          result_high_byte[7:2] == 6'h00;
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign bit not in high byte");

  property p_noise;
    @(posedge pclk) disable iff (!presetn)
    noise_start |=> state == ACRC_WAIT ##[1:200] state == ACRC_CONV;
  endproperty
  a_noise: assert property (p_noise)
    else $error("sleep entry did not start a conversion");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && nr_active && cpu_sleep) |=> cpu_wake ##1 !cpu_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake not a single pulse on completion");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (conv_end && irq_enable && !wr_ctrl) |=> ##1 conv_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("completion request missing");

  property p_en_kept;
    @(posedge pclk) disable iff (!presetn)
    (converter_enable_bit && !wr_ctrl) |=> converter_enable_bit;
  endproperty
  a_en_kept: assert property (p_en_kept)
    else $error("enable dropped without a write");

  c_free: cover property (@(posedge pclk) disable iff (!presetn)
    conv_end && free_run_select);
  c_wake: cover property (@(posedge pclk) disable iff (!presetn)
    cpu_wake);
  c_diff: cover property (@(posedge pclk) disable iff (!presetn)
    conv_end && act_diff);

endmodule
`default_nettype wire

/* verification/acrc_front_end.sv */
// Purpose: Analog front end stand-in that returns the value of the channel
//          latched by the converter.
// Assumes: The bench loads chan_in before it starts a conversion.
// Notes:   Outside the strobe the value is inverted, so a late capture shows.
`timescale 1ns/1ns
`default_nettype none
module acrc_front_end
(
  input wire logic sample_strobe,
  input wire logic [4:0] active_channel,
  input wire logic [31:0][15:0] chan_in,
  output logic signed [15:0] sample_value
);
  // ----------------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------------
  // Pin values stay still while a conversion runs; only the latched channel
  // is ever seen, so a selection change mid-conversion cannot leak in.
  assign sample_value = sample_strobe ? chan_in[active_channel]
                                      : ~chan_in[active_channel];
endmodule
`default_nettype wire

/* verification/adc_channel_result_control_test.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: APB answers within 20 cycles; prescale 0 keeps conversions short.
// Notes:   Corner values first, then seeded random channels and codes.
`timescale 1ns/1ns
`default_nettype none
module adc_channel_result_control_test;
  import acrc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] sample_value;
  logic [31:0][15:0] chan_in;
  logic sample_strobe, conv_busy, cpu_sleep, conv_irq, cpu_wake, woke;
  logic [4:0] active_channel;
  logic [1:0] active_reference;
  logic [2:0] sleep_mode;
  int failures, samples_checked;

  acrc_top i_acrc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_value(sample_value), .sample_strobe(sample_strobe),
    .active_channel(active_channel), .active_reference(active_reference),
    .conv_busy(conv_busy), .cpu_sleep(cpu_sleep), .sleep_mode(sleep_mode),
    .conv_irq(conv_irq), .cpu_wake(cpu_wake));
  acrc_front_end i_acrc_front_end (.sample_strobe(sample_strobe),
    .active_channel(active_channel), .chan_in(chan_in),
    .sample_value(sample_value));

  // ----------------------------------------------------------------------
  // Clock, checks and bus cycles
  // ----------------------------------------------------------------------
  // Free-running 25 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle follows so strobes never double up.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20)
    begin
      failures++;
      $display("[FAIL] %0t bus transfer timed out", $time);
      stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Expected code: clamp single-ended, saturate differential.
  function automatic logic [9:0] code(input int v, input logic d);
    if (d)
      return v > 511 ? 10'h1FF : v < -512 ? 10'h200 : v[9:0];
    return v > 1023 ? 10'h3FF : v < 0 ? 10'h000 : v[9:0];
  endfunction

  // Expected {high, low} byte pair for either adjustment.
  function automatic logic [15:0] pack(input logic [9:0] c, input logic l);
    return l ? {c, 6'h00} : {6'h00, c};
  endfunction

  // Runs one conversion, then checks both byte layouts.
  task automatic conv(input logic [4:0] ch, input int v, input logic l);
    logic [9:0] e;
    logic [7:0] lo;
    logic [1:0] r;
    int n;
    e = code(v, ch >= 5'h08 && ch <= 5'h1D);
    r = 2'($urandom % 4);
    chan_in[ch] <= v[15:0];
    // Selection is written only while idle. The model settles at once, so
    // the first result after a channel or reference change is kept.
    apb(1'b1, 8'h00, {24'h0, r, l, ch});
    apb(1'b1, 8'h04, 32'hC0);
    n = 0;
    do
    begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end
    while (rd[6] !== 1'b0 && n < 100);
    chk(rd & 32'h50, 32'h10);
    chk({24'h0, conv_busy, active_reference, active_channel},
        {24'h0, 1'b0, r, ch});
    apb(1'b0, 8'h08, 32'h0);
    lo = rd[7:0];
    apb(1'b0, 8'h0C, 32'h0);
    chk({rd[23:0], lo}, {16'h0, pack(e, l)});
    apb(1'b1, 8'h00, {26'h0, ~l, ch});
    apb(1'b0, 8'h08, 32'h0);
    lo = rd[7:0];
    apb(1'b0, 8'h0C, 32'h0);
    chk({rd[23:0], lo}, {16'h0, pack(e, ~l)});
    apb(1'b1, 8'h04, 32'h90);
  endtask

  // Polls the control register until the done flag shows, bounded.
  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end
    while (rd[4] !== 1'b1 && n < 100);
    chk(rd & 32'h10, 32'h10);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Corners first, then random traffic, then the sleep sequences.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_sleep = 1'b0;
    sleep_mode = 3'h0;
    presetn = 1'b0;
    chan_in = '0;
    void'($urandom(32'hD829));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    conv(5'h03, 32'h500, 1'b1);
    conv(5'h0D, -400, 1'b1);
    conv(5'h08, -700, 1'b0);
    conv(5'h10, 600, 1'b1);
    for (int i = 0; i < 6; i++)
      if (i % 2 == 1)
        conv(5'(8 + $urandom % 22), int'($urandom % 1400) - 700, 1'($urandom));
      else
        conv(5'($urandom % 8), int'($urandom % 2048), 1'($urandom));
    chan_in[3] <= 16'sh155;
    apb(1'b1, 8'h00, 32'h03);
    apb(1'b1, 8'h04, 32'h88);
    cpu_sleep <= 1'b1;
    sleep_mode <= 3'h1;
    woke = 1'b0;
    for (int n = 0; n < 400 && woke !== 1'b1; n++)
    begin
      @(posedge pclk);
      woke = cpu_wake;
    end
    chk({31'h0, woke}, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, conv_irq}, 32'h1);
    cpu_sleep <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h55);
    apb(1'b1, 8'h04, 32'h98);
    sleep_mode <= 3'h2;
    cpu_sleep <= 1'b1;
    repeat (100) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk({30'h0, rd[7:6]}, 32'h2);
    cpu_sleep <= 1'b0;
    // Off and on again after that sleep forces a long, valid conversion.
    apb(1'b1, 8'h04, 32'h0);
    conv(5'h0D, 300, 1'b0);
    // Free running: a selection written after the first result only
    // reaches the conversion after the one already under way.
    chan_in[1] <= 16'sh64;
    chan_in[2] <= 16'shC8;
    apb(1'b1, 8'h00, 32'h01);
    apb(1'b1, 8'h04, 32'hE0);
    wait_done;
    apb(1'b1, 8'h00, 32'h02);
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, 8'h04, 32'hB0);
      wait_done;
      chk({31'h0, conv_busy}, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, (k == 0) ? 32'h64 : 32'hC8);
    end
    stop_test;
  end

  // Watchdog against a hung run.
  initial
  begin
    repeat (100000) @(posedge pclk);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test;
  end
endmodule
`default_nettype wire
